// >>> pkg/bprc_cfg.svh
// constants for the buffered pwm reload control block
//
// Contract
// - only a channel-1 compare write arms the shadow transfer.
// - armed transfer loads all four shadows at counter clear; compare uses shadows.
// - no compare rewrite until period match after an armed transfer.
// - duty value zero gives output never active.
// - duty zero with period all ones still raises duty match each period.
// - duty equal to period plus one gives output always active.
// - period all ones cannot give a full-period active output.
// - active width is duty counts; period is period value plus one counts.
// - run bit set takes counter from all ones to zero and starts output.
// - period match fires on the count after counter matches period and clears.
// - duty match fires when counter equals that channel's shadow value.
`ifndef BPRC_CFG_SVH
`define BPRC_CFG_SVH
`define BPRC_WIDTH      16
`define BPRC_CNT_IDLE   16'hffff
`define BPRC_CNT_ZERO   16'h0000
`define BPRC_CNT_STEP   16'h0001
`define BPRC_SEL_PERIOD 2'h0
`define BPRC_SEL_DUTY1  2'h1
`define BPRC_SEL_DUTY2  2'h2
`define BPRC_SEL_DUTY3  2'h3
`endif

// >>> pkg/bprc_pkg.sv
// types for the buffered pwm reload control block
package bprc_pkg;
    typedef logic [15:0] bprc_value_type;
    typedef logic [1:0]  bprc_sel_type;
endpackage

// >>> verification/bprc_pwm_timer_tb_top.sv
// self-checking bench for the buffered pwm timer
module bprc_pwm_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clock = 1'b0;
    logic                     reset_n = 1'b0;
    logic                     counterRunBit = 1'b0;
    logic                     writeStrobe = 1'b0;
    bprc_pkg::bprc_sel_type   writeSel = 2'h0;
    bprc_pkg::bprc_value_type writeData = 16'h0000;
    logic                     transferArmed;
    bprc_pkg::bprc_value_type counterValue;
    logic                     periodMatchIrq;
    logic                     duty1MatchIrq;
    logic                     duty2MatchIrq;
    logic                     duty3MatchIrq;
    logic                     pwmOut1;
    logic                     pwmOut2;
    logic                     pwmOut3;
    int                       errors = 0;
    int                       compares = 0;
    int                       cycles = 0;
    int                       hi [3];
    int                       irq [4];
    // period, duty1, duty2, duty3
    logic [15:0]              rows [3][4] = '{'{16'h0007, 16'h0000, 16'h0003, 16'h0008},
                                              '{16'h0004, 16'h0005, 16'h0001, 16'h0004},
                                              '{16'h0000, 16'h0001, 16'h0000, 16'h0001}};

    bprc_pwm_timer dut
    (
        .clock          (clock),
        .reset_n        (reset_n),
        .counterRunBit  (counterRunBit),
        .writeStrobe    (writeStrobe),
        .writeSel       (writeSel),
        .writeData      (writeData),
        .transferArmed  (transferArmed),
        .counterValue   (counterValue),
        .periodMatchIrq (periodMatchIrq),
        .duty1MatchIrq  (duty1MatchIrq),
        .duty2MatchIrq  (duty2MatchIrq),
        .duty3MatchIrq  (duty3MatchIrq),
        .pwmOut1        (pwmOut1),
        .pwmOut2        (pwmOut2),
        .pwmOut3        (pwmOut3)
    );

    always #4 clock = ~clock;

    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 90000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input bprc_pkg::bprc_sel_type s, input bprc_pkg::bprc_value_type v);
        @(posedge clock);
        writeStrobe <= 1'b1;
        writeSel <= s;
        writeData <= v;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask

    task automatic waitPm();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end while (periodMatchIrq !== 1'b1 && n < 40);
        chk(periodMatchIrq, 1'b1);
    endtask

    task automatic load(input logic [15:0] p, d1, d2, d3);
        @(posedge clock);
        counterRunBit <= 1'b0;
        wr(2'h0, p);
        wr(2'h2, d2);
        wr(2'h3, d3);
        wr(2'h1, d1);
        #1;
        chk(counterValue, 16'hffff);
        repeat (3) @(posedge clock);
        counterRunBit <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    // counts levels and pulses over k whole periods
    task automatic measure(input logic [15:0] p, d1, d2, d3, input int k);
        logic [15:0] d [3];
        d = '{d1, d2, d3};
        hi = '{0, 0, 0};
        irq = '{0, 0, 0, 0};
        repeat (k * (p + 1))
        begin
            @(posedge clock);
            #1;
            hi[0] += int'(pwmOut1 === 1'b1);
            hi[1] += int'(pwmOut2 === 1'b1);
            hi[2] += int'(pwmOut3 === 1'b1);
            irq[0] += int'(periodMatchIrq === 1'b1);
            irq[1] += int'(duty1MatchIrq === 1'b1);
            irq[2] += int'(duty2MatchIrq === 1'b1);
            irq[3] += int'(duty3MatchIrq === 1'b1);
        end
        chk(irq[0], k);
        for (int i = 0; i < 3; i++)
        begin
            chk(hi[i], k * ((d[i] > p) ? p + 1 : d[i]));
            chk(irq[i + 1], (d[i] > p) ? 0 : k);
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        foreach (rows[r])
        begin
            load(rows[r][0], rows[r][1], rows[r][2], rows[r][3]);
            measure(rows[r][0], rows[r][1], rows[r][2], rows[r][3], 4);
        end
        // reset in mid-run
        @(posedge clock);
        reset_n <= 1'b0;
        #1;
        chk(counterValue, 16'hffff);
        chk({transferArmed, pwmOut1, pwmOut2, pwmOut3}, 4'h0);
        @(posedge clock);
        reset_n <= 1'b1;
        // non-channel-1 writes alone leave the waveform as it was
        load(16'h0007, 16'h0002, 16'h0002, 16'h0002);
        waitPm();
        wr(2'h0, 16'h0009);
        wr(2'h2, 16'h0005);
        wr(2'h3, 16'h0001);
        #1;
        chk(transferArmed, 1'b0);
        measure(16'h0007, 16'h0002, 16'h0002, 16'h0002, 2);
        waitPm();
        wr(2'h1, 16'h0006);
        #1;
        chk(transferArmed, 1'b1);
        waitPm();
        measure(16'h0009, 16'h0006, 16'h0005, 16'h0001, 2);
        // period-only change, then rewrite channel 1 unchanged
        wr(2'h0, 16'h000b);
        wr(2'h1, 16'h0006);
        waitPm();
        measure(16'h000b, 16'h0006, 16'h0005, 16'h0001, 1);
        // channels 2 and 3 only
        wr(2'h2, 16'h0003);
        wr(2'h3, 16'h000c);
        wr(2'h1, 16'h0006);
        waitPm();
        measure(16'h000b, 16'h0006, 16'h0003, 16'h000c, 1);
        // channel 1 only
        wr(2'h1, 16'h0000);
        waitPm();
        measure(16'h000b, 16'h0000, 16'h0003, 16'h000c, 1);
        // all duties
        wr(2'h2, 16'h0008);
        wr(2'h3, 16'h0002);
        wr(2'h1, 16'h0004);
        waitPm();
        measure(16'h000b, 16'h0004, 16'h0008, 16'h0002, 1);
        // full-range period: duty zero still matches, no full-period level
        load(16'hffff, 16'h0000, 16'hffff, 16'h0001);
        measure(16'hffff, 16'h0000, 16'hffff, 16'h0001, 1);
        summarize();
    end
endmodule

// >>> verilog/bprc_duty_channel.sv
// one duty channel: match pulse from the shadow value; output level held low
`include "bprc_cfg.svh"
module bprc_duty_channel
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // counter state
    input  wire logic              running,
    input  wire logic              counterClear,
    input  wire bprc_pkg::bprc_value_type counter,
    input  wire bprc_pkg::bprc_value_type shadow,
    // outputs
    output logic                   pwmOut,
    output logic                   matchIrq
);
    logic [`BPRC_WIDTH:0] shadowWide;
    assign shadowWide = {1'b0, shadow};

    // level is registered but always loads zero; the top drives the waveform itself
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pwmOut <= 1'b0;
        else
            pwmOut <= 1'b0;
    end

    // match pulse when counter equals shadow (also for zero)
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            matchIrq <= 1'b0;
        else
            matchIrq <= running && (counter == shadow);
    end
endmodule

// >>> verilog/bprc_pwm_timer.sv
// top of the buffered pwm timer: counter, compare registers, shadows
`include "bprc_cfg.svh"
module bprc_pwm_timer
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // control
    input  wire logic              counterRunBit,
    // compare register write port
    input  wire logic              writeStrobe,
    input  wire bprc_pkg::bprc_sel_type   writeSel,
    input  wire bprc_pkg::bprc_value_type writeData,
    // status
    output logic                   transferArmed,
    output bprc_pkg::bprc_value_type counterValue,
    // interrupts
    output logic                   periodMatchIrq,
    output logic                   duty1MatchIrq,
    output logic                   duty2MatchIrq,
    output logic                   duty3MatchIrq,
    // waveform
    output logic                   pwmOut1,
    output logic                   pwmOut2,
    output logic                   pwmOut3
);
    bprc_pkg::bprc_value_type compareReg [4];
    bprc_pkg::bprc_value_type compareShadow [4];
    bprc_pkg::bprc_value_type next_compareShadow [4];
    logic                     running;
    logic                     counterClear;
    logic                     clearSeen;
    logic [2:0]               dutyIrq;
    logic [2:0]               dutyOut;

    // counter wraps after matching the period shadow
    assign counterClear = running && (counterValue == compareShadow[0]);

    // compare registers written by software
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 4; i++)
                compareReg[i] <= `BPRC_CNT_ZERO;
        end
        else if (writeStrobe)
            compareReg[writeSel] <= writeData;
    end

    // arm only on a channel-1 write; new arm wins over consuming clear
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            transferArmed <= 1'b0;
        else if (writeStrobe && writeSel == `BPRC_SEL_DUTY1)
            transferArmed <= 1'b1;
        else if (counterClear || !running)
            transferArmed <= 1'b0;
    end

    // shadow in force for the next count: registers at armed clear or while stopped
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            next_compareShadow[i] = (!running || (counterClear && transferArmed))
                                    ? compareReg[i] : compareShadow[i];
    end

    // shadows loaded at clear when armed, or directly while stopped
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 4; i++)
                compareShadow[i] <= `BPRC_CNT_ZERO;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                compareShadow[i] <= next_compareShadow[i];
        end
    end

    // run bit: idle at all ones, step to zero on start
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            running      <= 1'b0;
            counterValue <= `BPRC_CNT_IDLE;
        end
        else if (!counterRunBit)
        begin
            running      <= 1'b0;
            counterValue <= `BPRC_CNT_IDLE;
        end
        else if (!running)
        begin
            running      <= 1'b1;
            counterValue <= `BPRC_CNT_ZERO;
        end
        else if (counterClear)
            counterValue <= `BPRC_CNT_ZERO;
        else
            counterValue <= counterValue + `BPRC_CNT_STEP;
    end

    // period match one count after the clear
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clearSeen      <= 1'b0;
            periodMatchIrq <= 1'b0;
        end
        else
        begin
            clearSeen      <= counterClear;
            periodMatchIrq <= clearSeen && running;
        end
    end

    // duty levels: active while count below shadow
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            dutyOut <= 3'h0;
        else
        begin
            for (int k = 0; k < 3; k++)
                dutyOut[k] <= counterRunBit && running && !counterClear
                              ? (counterValue + `BPRC_CNT_STEP < compareShadow[k + 1])
                              : (counterRunBit && next_compareShadow[k + 1] != `BPRC_CNT_ZERO);
        end
    end
    // 16-bit shadow cannot exceed all-ones period

    assign pwmOut1 = dutyOut[0];
    assign pwmOut2 = dutyOut[1];
    assign pwmOut3 = dutyOut[2];

    bprc_duty_channel ch1
    (
        .clock        (clock),
        .reset_n      (reset_n),
        .running      (running),
        .counterClear (counterClear),
        .counter      (counterValue),
        .shadow       (compareShadow[1]),
        .pwmOut       (),
        .matchIrq     (dutyIrq[0])
    );
    bprc_duty_channel ch2
    (
        .clock        (clock),
        .reset_n      (reset_n),
        .running      (running),
        .counterClear (counterClear),
        .counter      (counterValue),
        .shadow       (compareShadow[2]),
        .pwmOut       (),
        .matchIrq     (dutyIrq[1])
    );
    bprc_duty_channel ch3
    (
        .clock        (clock),
        .reset_n      (reset_n),
        .running      (running),
        .counterClear (counterClear),
        .counter      (counterValue),
        .shadow       (compareShadow[3]),
        .pwmOut       (),
        .matchIrq     (dutyIrq[2])
    );
    assign duty1MatchIrq = dutyIrq[0];
    assign duty2MatchIrq = dutyIrq[1];
    assign duty3MatchIrq = dutyIrq[2];

    chk_arm_only_ch1: assert property (@(posedge clock) disable iff (!reset_n)
        (writeStrobe && writeSel != `BPRC_SEL_DUTY1 && !transferArmed && running)
        |=> !transferArmed) else $error("arm without channel-1 write");
    chk_shadow_load: assert property (@(posedge clock) disable iff (!reset_n)
        (counterClear && transferArmed && !writeStrobe)
        |=> compareShadow[1] == $past(compareReg[1])) else $error("shadow not loaded");
    chk_shadow_hold: assert property (@(posedge clock) disable iff (!reset_n)
        (running && !counterClear && $past(running)) |=> $stable(compareShadow[0]))
        else $error("shadow moved mid period");
    chk_start_zero: assert property (@(posedge clock) disable iff (!reset_n)
        (counterRunBit && !running) |=> counterValue == `BPRC_CNT_ZERO)
        else $error("start not at zero");
    chk_period_irq: assert property (@(posedge clock) disable iff (!reset_n)
        (counterClear && counterRunBit) |=> ##1 periodMatchIrq)
        else $error("period match late");
    chk_wrap_zero: assert property (@(posedge clock) disable iff (!reset_n)
        (counterClear && counterRunBit) |=> counterValue == `BPRC_CNT_ZERO)
        else $error("counter did not clear");
    chk_duty_irq: assert property (@(posedge clock) disable iff (!reset_n)
        (running && counterValue == compareShadow[2]) |=> duty2MatchIrq)
        else $error("duty match missing");
    chk_zero_duty: assert property (@(posedge clock) disable iff (!reset_n)
        (compareShadow[1] == `BPRC_CNT_ZERO && $past(compareShadow[1]) == `BPRC_CNT_ZERO
         && running && $past(running) && !(counterClear && transferArmed)) |=> !pwmOut1)
        else $error("zero duty drove output");
    cov_reload: cover property (@(posedge clock) counterClear && transferArmed);
    cov_irq1: cover property (@(posedge clock) duty1MatchIrq);
    cov_period: cover property (@(posedge clock) periodMatchIrq);
endmodule
